// *** pcd_mgmt_regs.vh ***
/*
 * register offsets, field positions, reset values and frame timing for
 * the transceiver interrupt and cable diagnostic management registers.
 * assumes 5-bit register addresses carried by the serial management bus.
 */
`ifndef PCD_MGMT_REGS_VH
`define PCD_MGMT_REGS_VH

// register addresses
`define PCD_REG_INT 5'h1b
`define PCD_REG_DIAG 5'h1d
`define PCD_REG_CTL1 5'h1e
`define PCD_REG_CTL2 5'h1f

// interrupt control/status fields
`define PCD_INT_EN_MSB 15
`define PCD_INT_EN_LSB 8
`define PCD_INT_FLAG_MSB 7
`define PCD_INT_EN_RST 8'h00
`define PCD_INT_FLAG_RST 8'h00

// cable diagnostic fields
`define PCD_DIAG_GO_BIT 15
`define PCD_DIAG_RES_MSB 14
`define PCD_DIAG_RES_LSB 13
`define PCD_DIAG_CNT_MSB 8
`define PCD_DIAG_GO_RST 1'b0
`define PCD_DIAG_RES_RST 2'h0
`define PCD_DIAG_CNT_RST 9'h000

// first and second phy control fields
`define PCD_LED_MSB 15
`define PCD_LED_LSB 14
`define PCD_POL_BIT 13
`define PCD_LED_RST 2'h0
`define PCD_INTLVL_BIT 9
`define PCD_INTLVL_RST 1'b0

// serial frame layout
`define PCD_PRE_LEN 6'd32
`define PCD_HDR_LAST 4'hc
`define PCD_DATA_LAST 4'hf
`define PCD_OP_RD 2'h2
`define PCD_OP_WR 2'h1
`define PCD_PHY_ADDR_DEF 5'h01

`endif

// *** pcd_sync_edge.v ***
/*
 * two flip-flop synchroniser with rising edge detect.
 * assumes the input is asynchronous to i_sys_clk and changes slower than
 * two clock periods.
 */
`timescale 1ns/1ps
`default_nettype none

module pcd_sync_edge (
   // clock and reset
   input wire i_sys_clk,
   input wire i_sys_rst,
   // asynchronous input
   input wire i_async,
   // synchronised level and edge
   output wire o_level,
   output wire o_rise
);

   reg meta_ff;
   reg sync_ff;
   reg last_ff;

   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign o_level = sync_ff;
   assign o_rise = sync_ff & ~last_ff;

endmodule

`default_nettype wire

// *** pcd_mgmt_regs.v ***
/*
 * serial management slave holding the interrupt control/status, cable
 * diagnostic control/status and phy control registers.
 * assumes the management clock and data pins are asynchronous and slow
 * against i_sys_clk, and that events, diagnostic results and polarity
 * come from logic on i_sys_clk.
 */
// Functional notes
// - bit 8 of the interrupt register is a read/write link-up interrupt enable, reset zero.
// - bits 7 and 6 flag jabber and receive error, read-only, self-clearing, reset zero.
// - bits 5, 4, 3 flag page received, parallel detect fault, partner acknowledge.
// - bits 2, 1, 0 flag link down, remote fault and link up, self-clearing.
// - writing one to diagnostic bit 15 starts a test, hardware clears it when done.
// - diagnostic bits 14:13 give the result: normal, open, short or test failed.
// - diagnostic bits 8:0 give a read-only fault distance count, reset zero.
// - bit 13 of the first phy control register shows reversed receive polarity.
// - interrupt register bits 15:9 enable the other events, jabber at 15, reset zero.
// - the interrupt pin is active high when the level bit is one, else active low.
`timescale 1ns/1ps
`default_nettype none
`include "pcd_mgmt_regs.vh"

module pcd_mgmt_regs #(
   parameter [4:0] PHY_ADDR = `PCD_PHY_ADDR_DEF
) (
   // clock and reset
   input wire i_sys_clk,
   input wire i_sys_rst,
   // station management bus
   input wire i_mdc,
   input wire i_mdio,
   output reg o_mdio,
   output reg o_mdio_oe,
   // event pulses, bit order as the flag field
   input wire [7:0] i_evt,
   // cable diagnostic engine
   output reg o_diag_start,
   input wire i_diag_done,
   input wire [1:0] i_diag_result,
   input wire [8:0] i_diag_count,
   // line status and control
   input wire i_pol_reversed,
   output wire [1:0] o_led_mode,
   // interrupt pin
   output reg o_int
);

   localparam [2:0] ST_PRE = 3'h0;
   localparam [2:0] ST_HDR = 3'h1;
   localparam [2:0] ST_TA = 3'h2;
   localparam [2:0] ST_RD = 3'h3;
   localparam [2:0] ST_WR = 3'h4;

   wire mdc_rise;
   wire mdio_in;
   reg [2:0] state_ff;
   reg [5:0] pre_cnt_ff;
   reg [3:0] bit_cnt_ff;
   reg [15:0] shift_ff;
   reg [4:0] addr_ff;
   reg is_rd_ff;
   reg wr_stb_ff;
   reg [15:0] wr_data_ff;
   reg rd_clr_ff;
   reg [7:0] rd_mask_ff;

   reg [7:0] int_en_ff;
   reg [7:0] flag_ff;
   reg diag_go_ff;
   reg [1:0] diag_res_ff;
   reg [8:0] diag_cnt_ff;
   reg [1:0] led_ff;
   reg int_lvl_ff;

   wire [12:0] hdr;
   wire [4:0] hdr_reg;
   reg [15:0] rd_word;
   reg [7:0] nxt_flag;
   wire any_int;

   pcd_sync_edge u_mdc_sync (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_mdc),
      .o_level(),
      .o_rise(mdc_rise)
   );

   pcd_sync_edge u_mdio_sync (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_mdio),
      .o_level(mdio_in),
      .o_rise()
   );

   // start, opcode, phy address and register address as they complete
   assign hdr = {shift_ff[11:0], mdio_in};
   assign hdr_reg = hdr[4:0];

   // read value of the addressed register, unmapped reads give zero
   always @* begin
      rd_word = 16'h0000;
      case (hdr_reg)
         `PCD_REG_INT: begin
            rd_word = {int_en_ff, flag_ff};
         end
         `PCD_REG_DIAG: begin
            rd_word[`PCD_DIAG_GO_BIT] = diag_go_ff;
            rd_word[`PCD_DIAG_RES_MSB:`PCD_DIAG_RES_LSB] = diag_res_ff;
            rd_word[`PCD_DIAG_CNT_MSB:0] = diag_cnt_ff;
         end
         `PCD_REG_CTL1: begin
            rd_word[`PCD_LED_MSB:`PCD_LED_LSB] = led_ff;
            rd_word[`PCD_POL_BIT] = i_pol_reversed;
         end
         `PCD_REG_CTL2: begin
            rd_word[`PCD_INTLVL_BIT] = int_lvl_ff;
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   // serial frame engine, sampling data on each management clock rise
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state_ff <= ST_PRE;
         pre_cnt_ff <= 6'h00;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 16'h0000;
         addr_ff <= 5'h00;
         is_rd_ff <= 1'b0;
         wr_stb_ff <= 1'b0;
         wr_data_ff <= 16'h0000;
         rd_clr_ff <= 1'b0;
         rd_mask_ff <= 8'h00;
         o_mdio <= 1'b1;
         o_mdio_oe <= 1'b0;
      end else begin
         wr_stb_ff <= 1'b0;
         rd_clr_ff <= 1'b0;
         if (mdc_rise) begin
            case (state_ff)
               ST_PRE: begin
                  if (mdio_in) begin
                     if (pre_cnt_ff != `PCD_PRE_LEN) begin
                        pre_cnt_ff <= pre_cnt_ff + 6'h01;
                     end
                  end else begin
                     pre_cnt_ff <= 6'h00;
                     bit_cnt_ff <= 4'h0;
                     if (pre_cnt_ff == `PCD_PRE_LEN) begin
                        state_ff <= ST_HDR;
                     end
                  end
               end
               ST_HDR: begin
                  shift_ff <= {shift_ff[14:0], mdio_in};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  if (bit_cnt_ff == `PCD_HDR_LAST) begin
                     bit_cnt_ff <= 4'h0;
                     addr_ff <= hdr_reg;
                     if (hdr[12] && hdr[9:5] == PHY_ADDR &&
                         hdr[11:10] == `PCD_OP_RD) begin
                        state_ff <= ST_TA;
                        is_rd_ff <= 1'b1;
                        shift_ff <= rd_word;
                        if (hdr_reg == `PCD_REG_INT) begin
                           rd_clr_ff <= 1'b1;
                           rd_mask_ff <= flag_ff;
                        end
                     end else if (hdr[12] && hdr[9:5] == PHY_ADDR &&
                                  hdr[11:10] == `PCD_OP_WR) begin
                        state_ff <= ST_TA;
                        is_rd_ff <= 1'b0;
                     end else begin
                        state_ff <= ST_PRE;
                     end
                  end
               end
               ST_TA: begin
                  bit_cnt_ff <= 4'h1;
                  if (bit_cnt_ff == 4'h0) begin
                     o_mdio_oe <= is_rd_ff;
                     // the line only goes low when the device takes it over
                     o_mdio <= ~is_rd_ff;
                  end else begin
                     bit_cnt_ff <= 4'h0;
                     if (is_rd_ff) begin
                        state_ff <= ST_RD;
                        o_mdio <= shift_ff[15];
                        shift_ff <= {shift_ff[14:0], 1'b0};
                     end else begin
                        state_ff <= ST_WR;
                     end
                  end
               end
               ST_RD: begin
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  o_mdio <= shift_ff[15];
                  shift_ff <= {shift_ff[14:0], 1'b0};
                  if (bit_cnt_ff == `PCD_DATA_LAST) begin
                     o_mdio_oe <= 1'b0;
                     o_mdio <= 1'b1;
                     state_ff <= ST_PRE;
                  end
               end
               ST_WR: begin
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  shift_ff <= {shift_ff[14:0], mdio_in};
                  if (bit_cnt_ff == `PCD_DATA_LAST) begin
                     wr_stb_ff <= 1'b1;
                     wr_data_ff <= {shift_ff[14:0], mdio_in};
                     state_ff <= ST_PRE;
                  end
               end
               default: begin
                  state_ff <= ST_PRE;
                  o_mdio_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // new events win over the clear that follows a read
   always @* begin
      nxt_flag = flag_ff;
      if (rd_clr_ff) begin
         nxt_flag = flag_ff & ~rd_mask_ff;
      end
      nxt_flag = nxt_flag | i_evt;
   end

   // register bank
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         int_en_ff <= `PCD_INT_EN_RST;
         flag_ff <= `PCD_INT_FLAG_RST;
         diag_go_ff <= `PCD_DIAG_GO_RST;
         diag_res_ff <= `PCD_DIAG_RES_RST;
         diag_cnt_ff <= `PCD_DIAG_CNT_RST;
         led_ff <= `PCD_LED_RST;
         int_lvl_ff <= `PCD_INTLVL_RST;
         o_diag_start <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
         o_diag_start <= 1'b0;
         if (i_diag_done) begin
            diag_go_ff <= 1'b0;
            diag_res_ff <= i_diag_result;
            diag_cnt_ff <= i_diag_count;
         end
         if (wr_stb_ff) begin
            case (addr_ff)
               `PCD_REG_INT: begin
                  int_en_ff <= wr_data_ff[`PCD_INT_EN_MSB:`PCD_INT_EN_LSB];
               end
               `PCD_REG_DIAG: begin
                  if (wr_data_ff[`PCD_DIAG_GO_BIT] && !diag_go_ff) begin
                     diag_go_ff <= 1'b1;
                     o_diag_start <= 1'b1;
                  end
               end
               `PCD_REG_CTL1: begin
                  led_ff <= wr_data_ff[`PCD_LED_MSB:`PCD_LED_LSB];
               end
               `PCD_REG_CTL2: begin
                  int_lvl_ff <= wr_data_ff[`PCD_INTLVL_BIT];
               end
               default: begin
                  led_ff <= led_ff;
               end
            endcase
         end
      end
   end

   assign any_int = |(flag_ff & int_en_ff);
   assign o_led_mode = led_ff;

   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_int <= 1'b1;
      end else begin
         o_int <= int_lvl_ff ? any_int : ~any_int;
      end
   end

endmodule

`default_nettype wire

// *** pcd_mdio_host.sv ***
/* management bus master model driving the serial clock and data line.
   assumes a pull-up on the data line and a device that drives it on reads. */
`timescale 1ns/1ps
`default_nettype none
module pcd_mdio_host (
   // serial bus
   output logic o_mdc,
   output logic o_line,
   input wire logic i_dev_d,
   input wire logic i_dev_oe
);
   logic drv_en = 1'b0;
   logic drv_val = 1'b1;
   // a released line floats up to the pull-up level
   assign o_line = i_dev_oe ? i_dev_d : (drv_en ? drv_val : 1'b1);
   initial begin
      o_mdc = 1'b0;
   end
   // data set while the clock is low and held until the next fall
   task automatic bit_cyc(input logic en, input logic b, output logic s);
      drv_en = en;
      drv_val = b;
      #100;
      s = o_line;
      o_mdc = 1'b1;
      #100;
      o_mdc = 1'b0;
   endtask
   // one frame; the clock stands low again once it is over
   task automatic frame(input logic rd, input logic [4:0] phy,
         input logic [4:0] rg, input logic [15:0] wd,
         output logic [15:0] rdv);
      logic [45:0] hdr;
      logic s;
      hdr = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, phy, rg};
      for (int i = 45; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
      bit_cyc(!rd, 1'b1, s);
      bit_cyc(!rd, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_cyc(!rd, wd[i], s);
         rdv[i] = s;
      end
      drv_en = 1'b0;
      // idle gap so the next frame never retouches the line in this step
      #100;
   endtask
endmodule
`default_nettype wire

// *** pcd_mgmt_regs_monitor.sv ***
/* port checks for the management register block.
   assumes the serial clock stands still between frames. */
`timescale 1ns/1ps
`default_nettype none
module pcd_mgmt_regs_monitor (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // bus and side ports
   input wire logic i_mdc,
   input wire logic o_mdio,
   input wire logic o_mdio_oe,
   input wire logic [7:0] i_evt,
   input wire logic o_diag_start,
   input wire logic [1:0] o_led_mode,
   input wire logic o_int
);
   logic [5:0] quiet_ff;
   logic [7:0] span_ff;
   logic mdc_ff;
   logic live;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // cycles since the serial clock moved, and length of a drive window
   always @(posedge i_sys_clk) begin
      mdc_ff <= i_mdc;
      if (i_sys_rst || mdc_ff != i_mdc) quiet_ff <= 6'h00;
      else if (quiet_ff != 6'h3f) quiet_ff <= quiet_ff + 6'h01;
      if (!o_mdio_oe) span_ff <= 8'h00;
      else span_ff <= span_ff + 8'h01;
   end
   assign live = quiet_ff < 6'h28;
   sequence start_once;
      o_diag_start ##1 !o_diag_start;
   endsequence
   sequence drive_end;
      $fell(o_mdio_oe);
   endsequence
   reset_state_a: assert property ($fell(i_sys_rst) |-> o_int
      && !o_mdio_oe && !o_diag_start && o_led_mode == 2'h0)
      else $error("reset state wrong");
   idle_line_a: assert property (!o_mdio_oe |-> o_mdio)
      else $error("data line not idle high");
   start_pulse_a: assert property (o_diag_start |-> start_once)
      else $error("start pulse too long");
   start_cause_a: assert property (o_diag_start |-> live)
      else $error("start without a write");
   drive_cause_a: assert property ($rose(o_mdio_oe) |-> live)
      else $error("drive without a read");
   drive_span_a: assert property (drive_end |->
      span_ff inside {[8'd132:8'd140]}) else $error("read window length");
   led_hold_a: assert property (!live |-> $stable(o_led_mode))
      else $error("mode changed outside a write");
   int_cause_a: assert property ($changed(o_int) && !live |->
      $past(i_evt, 2) != 8'h00) else $error("interrupt moved without cause");
endmodule
bind pcd_mgmt_regs pcd_mgmt_regs_monitor i_mon (.i_sys_clk(i_sys_clk),
   .i_sys_rst(i_sys_rst), .i_mdc(i_mdc), .o_mdio(o_mdio),
   .o_mdio_oe(o_mdio_oe), .i_evt(i_evt), .o_diag_start(o_diag_start),
   .o_led_mode(o_led_mode), .o_int(o_int));
`default_nettype wire

// *** tb_top.sv ***
/* self-checking bench for the management register block.
   assumes the bus master model pcd_mdio_host and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst = 1'b1, done = 1'b0, pol = 1'b1;
   logic mdc, line, d_out, d_oe, start, irq;
   logic [7:0] evt = 8'h00;
   logic [1:0] res = 2'h0;
   logic [1:0] led;
   logic [8:0] cnt = 9'h000;
   logic [15:0] v;
   int n_fail = 0, samples_checked = 0, starts = 0;
   pcd_mgmt_regs #(.PHY_ADDR(5'h03)) i_dut (.i_sys_clk(clk), .i_sys_rst(rst),
      .i_mdc(mdc), .i_mdio(line), .o_mdio(d_out), .o_mdio_oe(d_oe),
      .i_evt(evt), .o_diag_start(start), .i_diag_done(done),
      .i_diag_result(res), .i_diag_count(cnt), .i_pol_reversed(pol),
      .o_led_mode(led), .o_int(irq));
   pcd_mdio_host i_host (.o_mdc(mdc), .o_line(line), .i_dev_d(d_out),
      .i_dev_oe(d_oe));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (start === 1'b1) starts <= starts + 1;
   end
   task automatic chk(input string nm, input logic [15:0] e,
         input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      i_host.frame(1'b1, 5'h03, a, 16'h0000, v);
      chk($sformatf("reg %h", a), e, v);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      i_host.frame(1'b0, 5'h03, a, d, v);
      repeat (10) @(negedge clk);
   endtask
   task automatic pulse(input logic [7:0] e);
      // let the serial clock go quiet so the checker sees a bare event
      repeat (44) @(negedge clk);
      evt = e;
      @(negedge clk);
      evt = 8'h00;
      repeat (4) @(negedge clk);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      n_fail++;
      conclude();
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rd(5'h1b, 16'h0000);
      rd(5'h1d, 16'h0000);
      rd(5'h1e, 16'h2000);
      @(negedge clk);
      pol = 1'b0;
      rd(5'h1e, 16'h0000);
      wr(5'h1e, 16'he000);
      chk("o_led_mode", 16'h0003, {14'h0, led});
      rd(5'h1e, 16'hc000);
      rd(5'h10, 16'h0000);
      i_host.frame(1'b1, 5'h01, 5'h1b, 16'h0000, v);
      chk("foreign address", 16'hffff, v);
      wr(5'h1b, 16'hffff);
      chk("o_int", 16'h0001, {15'h0, irq});
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i);
         chk("o_int", 16'h0000, {15'h0, irq});
         rd(5'h1b, 16'hff00 | (16'h0001 << i));
         rd(5'h1b, 16'hff00);
         chk("o_int", 16'h0001, {15'h0, irq});
      end
      wr(5'h1b, 16'h0000);
      pulse(8'h01);
      chk("o_int", 16'h0001, {15'h0, irq});
      rd(5'h1b, 16'h0001);
      wr(5'h1f, 16'h0200);
      chk("o_int", 16'h0000, {15'h0, irq});
      wr(5'h1b, 16'h0100);
      pulse(8'h01);
      chk("o_int", 16'h0001, {15'h0, irq});
      rd(5'h1b, 16'h0101);
      chk("o_int", 16'h0000, {15'h0, irq});
      for (int r = 0; r < 4; r++) begin
         wr(5'h1d, 16'h8000);
         chk("starts", 16'(r + 1), 16'(starts));
         if (r == 0) rd(5'h1d, 16'h8000);
         @(negedge clk);
         res = r[1:0];
         cnt = 9'h1ff >> r;
         done = 1'b1;
         @(negedge clk);
         done = 1'b0;
         rd(5'h1d, {1'b0, r[1:0], 4'h0, 9'h1ff >> r});
      end
      conclude();
   end
endmodule
`default_nettype wire
